// *** logic/servo_host_link.sv ***
// Purpose: Host command link, decoder relay, clock divider, reset and
//   laser control of a disc servo controller.
// Assumes: 200 MHz reference clock; host and oscillator pins are
//   asynchronous and are resynchronised here.
// Notes: Behaviour
`timescale 1ns/10ps
module servo_host_link (
	input wire logic i_ref_clk, // 200 MHz system clock.
	input wire logic i_reset, // Synchronous reset, active high.
	input wire logic i_i2c_mode, // High selects the 2-line bus.
	input wire logic i_host_serial_clock, // Host bit clock pin.
	input wire logic i_host_serial_line_in, // Host data pin level.
	output logic o_host_serial_line_out, // Host data drive value.
	output logic o_host_serial_line_oe, // High while driving host data.
	input wire logic i_host_load_control, // Host load/control pin.
	output logic o_wr_valid, // One-cycle local write strobe.
	output logic [3:0] o_wr_addr, // Local write index.
	output logic [7:0] o_wr_data, // Local write data.
	output logic [3:0] o_rd_addr, // Local read index.
	input wire logic [7:0] i_rd_data, // Local read data.
	output logic o_decoder_bit_clock, // Decoder bit clock.
	input wire logic i_decoder_serial_line_in, // Decoder data pin level.
	output logic o_decoder_serial_line_out, // Decoder data drive value.
	output logic o_decoder_serial_line_oe, // High while driving decoder.
	output logic o_decoder_frame_control, // High during a decoder byte.
	input wire logic i_oscillator_input, // Oscillator pin.
	output logic o_internal_clock, // Divided oscillator.
	output logic o_clock_buffer_output, // Clock buffer pin.
	output logic o_reset_output_inverted, // Low during reset.
	input wire logic i_focus_loop_on, // Focus loop enabled.
	output logic o_laser_drive_output_out, // Laser pin drive value.
	output logic o_laser_drive_output_oe, // High pulls laser pin low.
	output logic o_relay_overflow, // Sticky: decoder byte lost.
	output logic [7:0] o_ctrl // Control byte as written.
);
	import servo_link_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sck_s;
		logic [2:0] sda_s;
		logic [2:0] ld_s;
		logic [2:0] osc_s;
		logic [1:0] dln_s;
		logic [1:0] mode_s;
		host_state_e hst;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] cmd;
		logic [7:0] byte_cnt;
		logic [7:0] tx;
		logic reload;
		logic ack_due;
		logic drive;
		logic drive_bit;
		logic [7:0] gap_cnt;
		logic wr_valid;
		logic [3:0] wr_addr;
		logic [7:0] wr_data;
		logic [7:0] ctrl;
		logic overflow;
		dec_state_e dst;
		logic [4:0] dec_div;
		logic [3:0] dec_bit;
		logic [7:0] dec_sh;
		logic [7:0] dec_rx;
		logic dec_clk;
		logic dec_frame;
		logic [1:0] osc_cnt;
		logic int_clk;
		logic clk_half;
		logic clock_buffer_output;
		logic [5:0] rst_cnt;
		logic rst_out_n;
		logic laser_oe;
	} state_s;

	state_s q;
	state_s d;

	logic i2c;
	logic sda;
	logic sck_rise;
	logic sck_fall;
	logic ld_rise;
	logic ld_fall;
	logic i2c_start;
	logic i2c_stop;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [7:0] rd_value;
	logic [7:0] tx_next;
	logic buf_in_valid;
	logic buf_in_ready;
	logic [7:0] buf_in_data;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [7:0] buf_out_data;

	// ----------------------------------------------------------------
	// Command decoding
	// ----------------------------------------------------------------
	function automatic logic cmd_is_read(input logic [7:0] c);
		return c[CMD_READ_BIT];
	endfunction : cmd_is_read

	function automatic logic [7:0] cmd_count(input logic [7:0] c);
		return {5'h00, c[CMD_CNT_MSB:CMD_CNT_LSB]};
	endfunction : cmd_count

	function automatic logic [3:0] cmd_target(input logic [7:0] c);
		return c[3:0];
	endfunction : cmd_target

	function automatic logic [1:0] div_last(input logic [1:0] sel);
		case (sel)
			2'h1: return 2'h2;
			2'h2: return 2'h3;
			default: return 2'h1;
		endcase
	endfunction : div_last

	// ----------------------------------------------------------------
	// Decoder relay buffer
	// ----------------------------------------------------------------
	word_buffer #(
		.WIDTH(8),
		.DEPTH(2)
	) u_relay_buf (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_in_valid(buf_in_valid),
		.o_in_ready(buf_in_ready),
		.i_in_data(buf_in_data),
		.o_out_valid(buf_out_valid),
		.i_out_ready(buf_out_ready),
		.o_out_data(buf_out_data)
	);

	// ----------------------------------------------------------------
	// Edge events on the resynchronised lines
	// ----------------------------------------------------------------
	assign i2c = q.mode_s[1];
	assign sda = q.sda_s[1];
	assign sck_rise = q.sck_s[1] & ~q.sck_s[2];
	assign sck_fall = ~q.sck_s[1] & q.sck_s[2];
	assign ld_rise = ~i2c & q.ld_s[1] & ~q.ld_s[2];
	assign ld_fall = ~i2c & ~q.ld_s[1] & q.ld_s[2];
	assign i2c_start = i2c & q.sck_s[1] & q.sck_s[2] & ~sda & q.sda_s[2];
	assign i2c_stop = i2c & q.sck_s[1] & q.sck_s[2] & sda & ~q.sda_s[2];
	assign o_rd_addr = cmd_target(q.cmd) + q.byte_cnt[3:0];

	always_comb
	begin
		case (cmd_target(q.cmd))
			TGT_CTRL: rd_value = q.ctrl;
			TGT_STATUS: rd_value = {5'h00, q.overflow, buf_out_valid,
				q.dst == D_SHIFT};
			TGT_DECODER: rd_value = q.dec_rx;
			default: rd_value = i_rd_data;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;
		byte_done = 1'b0;
		rx_byte = q.shift;
		tx_next = q.tx;
		buf_in_valid = 1'b0;
		buf_in_data = 8'h00;
		buf_out_ready = 1'b0;
		d.wr_valid = 1'b0;

		// Two stages before use, the third only keeps history.
		d.sck_s = {q.sck_s[1:0], i_host_serial_clock};
		d.sda_s = {q.sda_s[1:0], i_host_serial_line_in};
		d.ld_s = {q.ld_s[1:0], i_host_load_control};
		d.osc_s = {q.osc_s[1:0], i_oscillator_input};
		d.dln_s = {q.dln_s[0], i_decoder_serial_line_in};
		d.mode_s = {q.mode_s[0], i_i2c_mode};

		// A silent load line ends an open 3-line exchange.
		if (i2c | ~q.ld_s[1])
			d.gap_cnt = 8'h00;
		else if (q.gap_cnt != 8'(EXCH_GAP_CYC))
			d.gap_cnt = q.gap_cnt + 8'h01;
		if (~i2c && q.gap_cnt == 8'(EXCH_GAP_CYC) && q.hst != H_IDLE)
		begin
			d.hst = H_IDLE;
			d.drive = 1'b0;
		end

		// Framing: start/stop on the 2-line bus, load line on 3-line.
		if (i2c_start)
		begin
			d.hst = H_CMD;
			d.bit_cnt = 4'h0;
			d.ack_due = 1'b0;
			d.drive = 1'b0;
		end
		else if (i2c_stop)
		begin
			d.hst = H_IDLE;
			d.drive = 1'b0;
		end
		if (ld_fall)
		begin
			if (q.hst == H_IDLE)
				d.hst = H_CMD;
			d.bit_cnt = 4'h0;
			d.drive = (q.hst == H_RD);
			d.drive_bit = q.tx[7];
		end
		if (ld_rise)
		begin
			d.drive = 1'b0;
			if (q.bit_cnt == BYTE_BITS && q.hst != H_IDLE)
				byte_done = 1'b1;
		end

		// Bits are taken at the rising host clock edge.
		if (sck_rise && q.hst != H_IDLE)
		begin
			if (q.bit_cnt < BYTE_BITS)
			begin
				d.shift = {q.shift[6:0], sda};
				d.bit_cnt = q.bit_cnt + 4'h1;
				if (i2c && q.bit_cnt == BYTE_BITS - 4'h1)
				begin
					byte_done = 1'b1;
					rx_byte = {q.shift[6:0], sda};
				end
			end
			else if (i2c)
			begin
				if (q.hst == H_RD && sda)
					d.hst = H_DONE;
				d.bit_cnt = 4'h0;
				d.ack_due = 1'b0;
			end
		end

		// The line only changes while the host clock is low.
		if (sck_fall && q.hst != H_IDLE)
		begin
			if (q.hst == H_RD && q.bit_cnt != 4'h0 && q.bit_cnt < BYTE_BITS)
				tx_next = {q.tx[6:0], 1'b0};
			d.tx = tx_next;
			d.drive = (q.hst == H_RD) && (q.bit_cnt < BYTE_BITS);
			d.drive_bit = tx_next[7];
			if (i2c && q.bit_cnt == BYTE_BITS && q.ack_due)
			begin
				d.drive = 1'b1;
				d.drive_bit = 1'b0;
			end
		end

		// Whole bytes.
		if (byte_done)
		begin
			case (q.hst)
				H_CMD:
				begin
					d.cmd = rx_byte;
					d.byte_cnt = 8'h00;
					d.ack_due = 1'b1;
					if (cmd_is_read(rx_byte))
					begin
						d.hst = H_RD;
						d.reload = 1'b1;
					end
					else if (cmd_count(rx_byte) == 8'h00)
						d.hst = i2c ? H_DONE : H_IDLE;
					else
						d.hst = H_WR;
				end
				H_WR:
				begin
					d.ack_due = 1'b1;
					d.byte_cnt = q.byte_cnt + 8'h01;
					case (cmd_target(q.cmd))
						TGT_CTRL: d.ctrl = rx_byte;
						TGT_STATUS: d.overflow = 1'b0;
						TGT_DECODER:
						begin
							buf_in_valid = 1'b1;
							buf_in_data = rx_byte;
						end
						default:
						begin
							d.wr_valid = 1'b1;
							d.wr_addr = o_rd_addr;
							d.wr_data = rx_byte;
						end
					endcase
					if (q.byte_cnt + 8'h01 == cmd_count(q.cmd))
						d.hst = i2c ? H_DONE : H_IDLE;
				end
				H_RD:
				begin
					d.byte_cnt = q.byte_cnt + 8'h01;
					if (q.byte_cnt == READ_MAX - 8'h01)
						d.hst = H_DONE;
					else
						d.reload = 1'b1;
				end
				default:
					d.ack_due = 1'b0;
			endcase
		end
		if (buf_in_valid & ~buf_in_ready)
			d.overflow = 1'b1;

		// Fetch the next read byte once the address has settled.
		if (q.reload)
		begin
			d.tx = rd_value;
			d.reload = 1'b0;
		end

		// Decoder link master.
		case (q.dst)
			D_IDLE:
			begin
				d.dec_clk = 1'b0;
				d.dec_frame = 1'b0;
				if (~q.ctrl[CTRL_DEC_OFF] && buf_out_valid)
				begin
					buf_out_ready = 1'b1;
					d.dec_sh = buf_out_data;
					d.dec_frame = 1'b1;
					d.dec_bit = 4'h0;
					d.dec_div = 5'h00;
					d.dst = D_SHIFT;
				end
			end
			D_SHIFT:
			begin
				if (q.dec_div == 5'(DEC_HALF_CYC - 1))
				begin
					d.dec_div = 5'h00;
					d.dec_clk = ~q.dec_clk;
					if (~q.dec_clk)
						d.dec_rx = {q.dec_rx[6:0], q.dln_s[1]};
					else
					begin
						d.dec_sh = {q.dec_sh[6:0], 1'b0};
						d.dec_bit = q.dec_bit + 4'h1;
						if (q.dec_bit == BYTE_BITS - 4'h1)
						begin
							d.dst = D_IDLE;
							d.dec_frame = 1'b0;
						end
					end
				end
				else
					d.dec_div = q.dec_div + 5'h01;
			end
			default:
				d.dst = D_IDLE;
		endcase

		// Oscillator divider: each oscillator edge is half a period.
		if (q.osc_s[1] ^ q.osc_s[2])
		begin
			if (q.osc_cnt >= div_last(q.ctrl[CTRL_DIV_LSB+:2]))
			begin
				d.osc_cnt = 2'h0;
				d.int_clk = ~q.int_clk;
				if (~q.int_clk)
					d.clk_half = ~q.clk_half;
			end
			else
				d.osc_cnt = q.osc_cnt + 2'h1;
		end
		d.clock_buffer_output = q.ctrl[CTRL_CLOCK_BUFFER_OUTPUT_HALF] ? d.clk_half : d.int_clk;

		// Reset output stays low for the minimum reset time after release.
		if (q.rst_cnt != 6'(RESET_MIN_CYC))
			d.rst_cnt = q.rst_cnt + 6'h01;
		else
			d.rst_out_n = 1'b1;

		// Pulling the pin low keeps the laser off.
		d.laser_oe = ~(i_focus_loop_on | q.ctrl[CTRL_LASER_ON]);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
			q.laser_oe <= 1'b1;
		end
		else
			q <= d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_host_serial_line_out = i2c ? 1'b0 : q.drive_bit;
	assign o_host_serial_line_oe = q.drive & (~i2c | ~q.drive_bit);
	assign o_wr_valid = q.wr_valid;
	assign o_wr_addr = q.wr_addr;
	assign o_wr_data = q.wr_data;
	assign o_decoder_bit_clock = q.dec_clk;
	assign o_decoder_serial_line_out = q.dec_sh[7];
	assign o_decoder_serial_line_oe = q.dec_frame;
	assign o_decoder_frame_control = q.dec_frame;
	assign o_internal_clock = q.int_clk;
	assign o_clock_buffer_output = q.clock_buffer_output;
	assign o_reset_output_inverted = q.rst_out_n;
	assign o_laser_drive_output_out = 1'b0;
	assign o_laser_drive_output_oe = q.laser_oe;
	assign o_relay_overflow = q.overflow;
	assign o_ctrl = q.ctrl;

endmodule : servo_host_link

// *** common/servo_link_pkg.sv ***
// Purpose: Shared constants and types of the servo host link block.
// Assumes: Reference clock of 200 MHz (5 ns period).
// Notes: Command byte layout and target indices are fixed here.
package servo_link_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int REF_PERIOD_NS = 5;
	localparam int RESET_MIN_NS = 250;
	localparam int RESET_MIN_CYC = (RESET_MIN_NS + REF_PERIOD_NS - 1) /
		REF_PERIOD_NS;
	localparam int EXCH_GAP_NS = 1000;
	localparam int EXCH_GAP_CYC = (EXCH_GAP_NS + REF_PERIOD_NS - 1) /
		REF_PERIOD_NS;
	localparam int DEC_HALF_NS = 100;
	localparam int DEC_HALF_CYC = (DEC_HALF_NS + REF_PERIOD_NS - 1) /
		REF_PERIOD_NS;

	// ----------------------------------------------------------------
	// Command byte and transfer limits
	// ----------------------------------------------------------------
	localparam int CMD_READ_BIT = 7;
	localparam int CMD_CNT_MSB = 6;
	localparam int CMD_CNT_LSB = 4;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] READ_MAX = 8'h80;

	// ----------------------------------------------------------------
	// Target indices carried in the command byte
	// ----------------------------------------------------------------
	localparam logic [3:0] TGT_CTRL = 4'hd;
	localparam logic [3:0] TGT_STATUS = 4'he;
	localparam logic [3:0] TGT_DECODER = 4'hf;

	// ----------------------------------------------------------------
	// Control byte fields and reset value
	// ----------------------------------------------------------------
	localparam int CTRL_DIV_LSB = 0;
	localparam int CTRL_CLOCK_BUFFER_OUTPUT_HALF = 2;
	localparam int CTRL_DEC_OFF = 3;
	localparam int CTRL_LASER_ON = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// State machines
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {H_IDLE, H_CMD, H_WR, H_RD, H_DONE} host_state_e;
	typedef enum logic {D_IDLE, D_SHIFT} dec_state_e;

endpackage : servo_link_pkg

// *** logic/word_buffer.sv ***
// Purpose: Small FIFO with valid and ready on both sides.
// Assumes: Synchronous active-high reset; one clock.
// Notes: Full and empty follow the entry count exactly.
`timescale 1ns/10ps
module word_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic i_ref_clk, // System clock.
	input wire logic i_reset, // Synchronous reset, active high.
	input wire logic i_in_valid, // Word offered.
	output logic o_in_ready, // Room for a word.
	input wire logic [WIDTH-1:0] i_in_data, // Offered word.
	output logic o_out_valid, // Word available.
	input wire logic i_out_ready, // Drain takes the word.
	output logic [WIDTH-1:0] o_out_data // Oldest word.
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
	} buf_s;

	buf_s q;
	buf_s d;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		if (p == PW'(DEPTH - 1))
			return '0;
		return p + PW'(1);
	endfunction : bump

	assign o_in_ready = (q.cnt != CW'(DEPTH));
	assign o_out_valid = (q.cnt != '0);
	assign o_out_data = q.mem[q.rp];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	always_comb
	begin
		d = q;
		if (push)
		begin
			d.mem[q.wp] = i_in_data;
			d.wp = bump(q.wp);
		end
		if (pop)
			d.rp = bump(q.rp);
		if (push & ~pop)
			d.cnt = q.cnt + CW'(1);
		else if (pop & ~push)
			d.cnt = q.cnt - CW'(1);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			q <= '0;
		else
			q <= d;
	end

endmodule : word_buffer

// *** verif/servo_host_link_checker.sv ***
// Purpose: Port-level checks of the servo host link.
// Assumes: One clock; synchronous active-high reset.
// Notes: Reset checks stay armed while reset is high.
`timescale 1ns/10ps
module servo_host_link_checker (
	input wire logic i_ref_clk, // System clock.
	input wire logic i_reset, // Synchronous reset.
	input wire logic i_i2c_mode, // Bus mode.
	input wire logic i_host_load_control, // Load line.
	input wire logic o_host_serial_line_oe, // Host data enable.
	input wire logic o_wr_valid, // Local write strobe.
	input wire logic o_decoder_bit_clock, // Decoder clock.
	input wire logic o_decoder_serial_line_oe, // Decoder enable.
	input wire logic o_decoder_frame_control, // Decoder frame.
	input wire logic o_reset_output_inverted, // Reset out.
	input wire logic i_focus_loop_on, // Focus loop on.
	input wire logic o_laser_drive_output_oe, // Laser pull-down.
	input wire logic o_relay_overflow, // Lost relay byte.
	input wire logic [7:0] o_ctrl // Control byte.
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	logic [9:0] flen_r;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk)
		if (i_reset || !o_decoder_frame_control) flen_r <= 10'h0;
		else flen_r <= flen_r + 10'h1;
	rst_out_low_a: assert property (disable iff (1'b0) i_reset |=>
		!o_reset_output_inverted && o_ctrl == 8'h00)
		else $error("reset output or control not cleared");
	laser_rst_a: assert property (disable iff (1'b0) i_reset |=>
		o_laser_drive_output_oe) else $error("laser not off in reset");
	rst_out_hold_a: assert property ($fell(i_reset) |->
		!o_reset_output_inverted [*8]) else $error("reset out early");
	rst_out_rise_a: assert property ($fell(i_reset) |->
		##[40:60] o_reset_output_inverted) else $error("reset out stuck");
	laser_focus_a: assert property (i_focus_loop_on |->
		##[1:2] !o_laser_drive_output_oe) else $error("laser not on");
	host_oe_a: assert property ((!i_i2c_mode && i_host_load_control)
		[*5] |-> !o_host_serial_line_oe) else $error("drive outside byte");
	wr_pulse_a: assert property (o_wr_valid |=> !o_wr_valid)
		else $error("write strobe too long");
	frame_len_a: assert property ($fell(o_decoder_frame_control) |->
		flen_r inside {[10'd320:10'd345]}) else $error("frame length");
	dec_idle_a: assert property (!o_decoder_frame_control |->
		!o_decoder_bit_clock) else $error("decoder clock idle");
	dec_oe_a: assert property (o_decoder_serial_line_oe |->
		o_decoder_frame_control) else $error("decoder drive unframed");
	dec_off_a: assert property (o_ctrl[3] [*3] |->
		!$rose(o_decoder_frame_control)) else $error("frame while off");
	wr_c: cover property (o_wr_valid);
	frame_c: cover property ($rose(o_decoder_frame_control));
	ovf_c: cover property ($rose(o_relay_overflow));
endmodule : servo_host_link_checker

// *** verif/host_mcu_model.sv ***
// Purpose: Microcontroller model on the 3-line host bus.
// Assumes: Caller spaces exchanges; clock idles low.
// Notes: A released data line shows a changing pattern.
`timescale 1ns/10ps
module host_mcu_model (
	input wire logic i_ref_clk, // System clock.
	input wire logic i_line, // Resolved host data line.
	output logic o_clk, // Host bit clock.
	output logic o_data, // Host data, valid while writing.
	output logic o_load // Load/control line.
);
	initial
	begin
		o_clk = 1'b0;
		o_data = 1'b0;
		o_load = 1'b1;
	end
	task automatic half(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask : half
	// ------------------------------------------------------------
	// One byte framed by the load line, MSB first
	// ------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] tx,
		output logic [7:0] rx);
		half(2);
		o_load = 1'b0;
		for (int b = 7; b >= 0; b--)
		begin
			o_data = wr ? tx[b] : ~o_data;
			half(6);
			o_clk = 1'b1;
			rx[b] = i_line;
			half(6);
			o_clk = 1'b0;
		end
		o_data = ~o_data;
		half(2);
		o_load = 1'b1;
		half(6);
	endtask : xfer
endmodule : host_mcu_model

// *** verif/servo_host_link_tb_top.sv ***
// Purpose: Self-checking bench of the servo host link.
// Assumes: 3-line bus mode; local read data is a fixed map.
// Notes: Oscillator is 25 MHz, eight system cycles a period.
`timescale 1ns/10ps
module servo_host_link_tb_top;
	import servo_link_pkg::*;
	logic clk = 0, rst = 1, osc = 0, focus = 0, i2c_sel = 0;
	logic hclk, hdata, hload, hline, d_out, d_oe, dclk, frame;
	logic h_out, h_oe, wr_v, reset_output_inverted, ovf, intclk, clkbuf, las_oe, las_out;
	logic [3:0] wr_a, rd_a;
	logic [7:0] wr_d, ctrl, dsh, got;
	logic [11:0] wr_q[$];
	logic [7:0] dec_q[$];
	int err_total = 0, tests_run = 0, n;
	initial forever #2.5 clk = ~clk;
	initial
	begin
		#1.3;
		forever #20 osc = ~osc;
	end
	assign hline = h_oe ? h_out : hdata;
	host_mcu_model i_host (.i_ref_clk(clk), .i_line(hline), .o_clk(hclk),
		.o_data(hdata), .o_load(hload));
	servo_host_link i_dut (.i_ref_clk(clk), .i_reset(rst),
		.i_i2c_mode(i2c_sel), .i_host_serial_clock(hclk),
		.i_host_serial_line_in(hline), .o_host_serial_line_out(h_out),
		.o_host_serial_line_oe(h_oe), .i_host_load_control(hload),
		.o_wr_valid(wr_v), .o_wr_addr(wr_a), .o_wr_data(wr_d),
		.o_rd_addr(rd_a), .i_rd_data({rd_a, ~rd_a}),
		.o_decoder_bit_clock(dclk), .i_decoder_serial_line_in(~d_out),
		.o_decoder_serial_line_out(d_out), .o_decoder_serial_line_oe(d_oe),
		.o_decoder_frame_control(frame), .i_oscillator_input(osc),
		.o_internal_clock(intclk), .o_clock_buffer_output(clkbuf),
		.o_reset_output_inverted(reset_output_inverted), .i_focus_loop_on(focus),
		.o_laser_drive_output_out(las_out),
		.o_laser_drive_output_oe(las_oe), .o_relay_overflow(ovf),
		.o_ctrl(ctrl));
	always @(posedge clk) if (wr_v === 1'b1) wr_q.push_back({wr_a, wr_d});
	always @(posedge dclk) dsh <= {dsh[6:0], d_out};
	always @(negedge frame) dec_q.push_back(dsh);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [11:0] seen,
		input logic [11:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict
	task automatic send(input logic [7:0] cmd, input logic [23:0] d,
		input int cnt);
		logic [7:0] rx;
		i_host.xfer(1'b1, cmd, rx);
		for (int j = 0; j < cnt; j++) i_host.xfer(1'b1, d[23-8*j -: 8], rx);
		i_host.half(220);
	endtask : send
	task automatic meas(input logic sel, output int per);
		logic p, c;
		int t0;
		p = 1'b1;
		t0 = -1;
		per = 0;
		for (int k = 0; k < 300 && per == 0; k++)
		begin
			@(posedge clk);
			c = sel ? clkbuf : intclk;
			if (c === 1'b1 && p === 1'b0)
			begin
				if (t0 >= 0) per = k - t0;
				t0 = k;
			end
			p = c;
		end
	endtask : meas
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (RESET_MIN_CYC) @(posedge clk);
		#1;
		check("ctrl in reset", ctrl, 8'h00);
		check("laser in reset", las_oe, 1'b1);
		rst = 1'b0;
		repeat (10) @(posedge clk);
		wr_q.delete();
		dec_q.delete();
		check("reset out held", reset_output_inverted, 1'b0);
		repeat (60) @(posedge clk);
		check("reset out", reset_output_inverted, 1'b1);
		#1;
		send(8'h1d, 24'h040000, 1);
		check("ctrl write", ctrl, 8'h04);
		for (int i = 0; i < 8; i++)
		begin
			send(8'h1d, {5'h0, i[2:0], 16'h0}, 1);
			meas(i[2], n);
			check("clock period", n,
				(i[1:0] == 1 ? 24 : i[1:0] == 2 ? 32 : 16) << i[2]);
		end
		send(8'h1d, 24'h100000, 1);
		check("laser forced", las_oe, 1'b0);
		send(8'h1d, 24'h0, 1);
		check("laser off", las_oe, 1'b1);
		focus = 1'b1;
		repeat (3) @(posedge clk);
		check("laser focus", las_oe, 1'b0);
		check("laser pin", las_out, 1'b0);
		#1 focus = 1'b0;
		send(8'h23, 24'ha53c00, 3);
		check("write count", wr_q.size(), 2);
		check("write 0", wr_q[0], 12'h3a5);
		check("write 1", wr_q[1], 12'h43c);
		i_host.xfer(1'b1, 8'h85, got);
		i_host.xfer(1'b0, 8'h0, got);
		check("read 0", got, 8'h5a);
		i_host.xfer(1'b0, 8'h0, got);
		check("read 1", got, 8'h69);
		i_host.half(220);
		send(8'h1f, 24'hc30000, 1);
		i_host.half(400);
		check("relay count", dec_q.size(), 1);
		check("relay byte", dec_q[0], 8'hc3);
		i_host.xfer(1'b1, 8'h8f, got);
		i_host.xfer(1'b0, 8'h0, got);
		check("decoder input", got, 8'h3c);
		i_host.half(220);
		dec_q.delete();
		send(8'h1d, 24'h080000, 1);
		send(8'h3f, 24'h112233, 3);
		check("overflow", ovf, 1'b1);
		check("link held", dec_q.size(), 0);
		i_host.xfer(1'b1, 8'h8e, got);
		i_host.xfer(1'b0, 8'h0, got);
		check("status", got[7:2], 6'h01);
		i_host.half(220);
		send(8'h1d, 24'h0, 1);
		i_host.half(800);
		check("drained", dec_q.size(), 2);
		check("drain 0", dec_q[0], 8'h11);
		check("drain 1", dec_q[1], 8'h22);
		send(8'h1e, 24'h0, 1);
		check("overflow clear", ovf, 1'b0);
		give_verdict();
	end
	initial
	begin
		repeat (80000) @(posedge clk);
		err_total++;
		give_verdict();
	end
endmodule : servo_host_link_tb_top
bind servo_host_link servo_host_link_checker i_chk (.*);
